/* File: sde_drop_checker.sv */
// Assertions on the drop-event status block ports.
// Assumes binding to sde_drop_status with mask tracked from host writes.
`timescale 1ns/1ps
`include "sde_drop_status_regs.svh"

module sde_drop_checker (
	// Watched ports
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic drop_strobe,
	input wire logic switch_irq
);
	logic mask;
	always_ff @(posedge clock) begin
		if (sys_rst) mask <= 1'h1;
		else if (reg_wr && reg_addr == `SDE_ADDR_MASK) mask <= reg_wdata[0];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not idle");
	a_rsvd_zero: assert property (reg_rdata[31:15] == 17'h0_0000)
		else $error("reserved bits set");
	a_mask_gate: assert property (mask |-> !switch_irq)
		else $error("irq while masked");
	a_mask_value: assert property ($past(reg_rd) && $past(reg_addr) == `SDE_ADDR_MASK
		|-> reg_rdata == {31'h0000_0000, mask}) else $error("mask read wrong");
	a_drop_irq: assert property (drop_strobe && !reg_wr && !mask |=> switch_irq)
		else $error("drop without irq");
	a_drop_pend: assert property (drop_strobe ##1 (reg_rd && reg_addr == `SDE_ADDR_STATUS)
		|=> reg_rdata[0]) else $error("pending missing");
	a_read_clear: assert property ((reg_rd && reg_addr == `SDE_ADDR_STATUS && !drop_strobe)
		##1 (reg_rd && reg_addr == `SDE_ADDR_STATUS) |=> reg_rdata[14:0] == 15'h0000)
		else $error("status not cleared");
	a_b_after_a: assert property (reg_rdata[8] |-> reg_rdata[1] && reg_rdata[0])
		else $error("set B before set A");
	a_rsvd_code: assert property (!(reg_rdata[7:4] inside {4'hC, 4'hD, 4'hF}))
		else $error("reserved reason");
	a_irq_clear: assert property (reg_rd && reg_addr == `SDE_ADDR_STATUS && !drop_strobe
		|=> !switch_irq) else $error("irq after clear");
endmodule : sde_drop_checker

/* File: sde_drop_status.sv */
// Drop-event status register pair: double-buffered records plus mask.
// Assumes drop strobes and the register port share the switch clock.
`timescale 1ns/1ps
`include "sde_drop_status_regs.svh"

module sde_drop_status (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Drop events from the forwarding engine
	input wire logic drop_strobe,
	input wire logic [15:0] drop_cause,
	input wire logic [1:0] drop_src_port,
	// Interrupt towards system aggregation
	output logic switch_irq
);
	import sde_pkg::*;

	sde_state_t cur;
	sde_state_t next_cur;
	sde_reason_t enc_reason;
	logic enc_hit;
	logic [31:0] status_word;

	sde_reason_encode u_encode (
		.cause(drop_cause),
		.reason(enc_reason),
		.hit(enc_hit)
	);

	// Status image as software sees it; reserved bits read zero
	always_comb begin
		status_word = `SDE_WORD_ZERO;
		status_word[`SDE_PEND_BIT] = cur.pend;
		status_word[`SDE_A_VALID_BIT] = cur.a_valid;
		status_word[`SDE_A_PORT_HI:`SDE_A_PORT_LO] = cur.a_port;
		status_word[`SDE_A_REASON_HI:`SDE_A_REASON_LO] = cur.a_reason;
		status_word[`SDE_B_VALID_BIT] = cur.b_valid;
		status_word[`SDE_B_PORT_HI:`SDE_B_PORT_LO] = cur.b_port;
		status_word[`SDE_B_REASON_HI:`SDE_B_REASON_LO] = cur.b_reason;
	end

	always_comb begin
		next_cur = cur;
		next_cur.rdata = `SDE_WORD_ZERO;
		if (reg_rd) begin
			if (reg_addr == `SDE_ADDR_STATUS) begin
				next_cur.rdata = status_word;
				// Read clears whole word; a same-cycle drop is applied after
				next_cur.pend = 1'b0;
				next_cur.a_valid = 1'b0;
				next_cur.a_port = `SDE_PORT_RST;
				next_cur.a_reason = `SDE_REASON_RST;
				next_cur.b_valid = 1'b0;
				next_cur.b_port = `SDE_PORT_RST;
				next_cur.b_reason = `SDE_REASON_RST;
			end else if (reg_addr == `SDE_ADDR_MASK) begin
				next_cur.rdata[`SDE_MASK_BIT] = cur.mask;
			end
		end
		if (reg_wr && reg_addr == `SDE_ADDR_MASK) begin
			next_cur.mask = reg_wdata[`SDE_MASK_BIT];
		end
		// Capture runs regardless of mask
		if (drop_strobe) begin
			next_cur.pend = 1'b1;
			if (enc_hit) begin
				if (!next_cur.a_valid) begin
					next_cur.a_valid = 1'b1;
					next_cur.a_port = drop_src_port;
					next_cur.a_reason = enc_reason;
				end else if (!next_cur.b_valid) begin
					next_cur.b_valid = 1'b1;
					next_cur.b_port = drop_src_port;
					next_cur.b_reason = enc_reason;
				end
			end
		end
		// Only the pending summary, gated by the mask, feeds the interrupt
		next_cur.irq = next_cur.pend & ~next_cur.mask;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur <= '0;
			cur.mask <= `SDE_MASK_RST;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata = cur.rdata;
	assign switch_irq = cur.irq;

endmodule : sde_drop_status

/* File: sde_drop_status_regs.svh */
// Constants of the switch drop-event status block: offsets, fields, codes.
// Assumes a word-indexed host map; byte address is four times the index.
`ifndef SDE_DROP_STATUS_REGS_SVH
`define SDE_DROP_STATUS_REGS_SVH

// Register indices and byte addresses
`define SDE_IDX_MASK 16'h1880
`define SDE_IDX_STATUS 16'h1881
`define SDE_ADDR_MASK 16'(`SDE_IDX_MASK * 16'h0004)
`define SDE_ADDR_STATUS 16'(`SDE_IDX_STATUS * 16'h0004)

// Status and mask field positions
`define SDE_PEND_BIT 0
`define SDE_A_VALID_BIT 1
`define SDE_A_PORT_LO 2
`define SDE_A_PORT_HI 3
`define SDE_A_REASON_LO 4
`define SDE_A_REASON_HI 7
`define SDE_B_VALID_BIT 8
`define SDE_B_PORT_LO 9
`define SDE_B_PORT_HI 10
`define SDE_B_REASON_LO 11
`define SDE_B_REASON_HI 14
`define SDE_MASK_BIT 0

// Reset values
`define SDE_MASK_RST 1'h1
`define SDE_WORD_ZERO 32'h0000_0000
`define SDE_PORT_RST 2'h0
`define SDE_REASON_RST 4'h0

// Drop reason codes
`define SDE_RSN_UNTAGGED 4'h0
`define SDE_RSN_UNK_SRC_NONMEMBER 4'h1
`define SDE_RSN_SRC_BLOCKED 4'h2
`define SDE_RSN_DST_BLOCKED 4'h3
`define SDE_RSN_DST_NONMEMBER 4'h4
`define SDE_RSN_SRC_NONMEMBER 4'h5
`define SDE_RSN_UNK_UNICAST 4'h6
`define SDE_RSN_UNK_MULTICAST 4'h7
`define SDE_RSN_BCAST_THROTTLE 4'h8
`define SDE_RSN_UNK_SRC_BLOCKED 4'h9
`define SDE_RSN_SAME_PORT 4'hA
`define SDE_RSN_FILTERED 4'hB
`define SDE_RSN_VID_ALL_ONES 4'hE

// Cause lines that may be reported; 1100, 1101, 1111 are reserved
`define SDE_RSN_LEGAL 16'h4FFF

`endif

/* File: sde_pkg.sv */
// Types shared by the drop-event status block and its reason encoder.
// Assumes sde_drop_status_regs.svh supplies every numeric constant.
`include "sde_drop_status_regs.svh"

package sde_pkg;

	typedef enum logic [3:0] {
		sde_rsn_untagged = `SDE_RSN_UNTAGGED,
		sde_rsn_unk_src_nonmember = `SDE_RSN_UNK_SRC_NONMEMBER,
		sde_rsn_src_blocked = `SDE_RSN_SRC_BLOCKED,
		sde_rsn_dst_blocked = `SDE_RSN_DST_BLOCKED,
		sde_rsn_dst_nonmember = `SDE_RSN_DST_NONMEMBER,
		sde_rsn_src_nonmember = `SDE_RSN_SRC_NONMEMBER,
		sde_rsn_unk_unicast = `SDE_RSN_UNK_UNICAST,
		sde_rsn_unk_multicast = `SDE_RSN_UNK_MULTICAST,
		sde_rsn_bcast_throttle = `SDE_RSN_BCAST_THROTTLE,
		sde_rsn_unk_src_blocked = `SDE_RSN_UNK_SRC_BLOCKED,
		sde_rsn_same_port = `SDE_RSN_SAME_PORT,
		sde_rsn_filtered = `SDE_RSN_FILTERED,
		sde_rsn_vid_all_ones = `SDE_RSN_VID_ALL_ONES
	} sde_reason_t;

	typedef struct packed {
		logic pend;
		logic a_valid;
		logic [1:0] a_port;
		logic [3:0] a_reason;
		logic b_valid;
		logic [1:0] b_port;
		logic [3:0] b_reason;
		logic mask;
		logic irq;
		logic [31:0] rdata;
	} sde_state_t;

endpackage : sde_pkg

/* File: sde_reason_encode.sv */
// Drop-cause priority encoder: one cause line per reason code.
// Assumes cause lines come from forwarding logic on the same clock.
`timescale 1ns/1ps
`include "sde_drop_status_regs.svh"

module sde_reason_encode (
	// Cause lines, bit n asserts reason code n
	input wire logic [15:0] cause,
	// Encoded result
	output sde_pkg::sde_reason_t reason,
	output logic hit
);
	import sde_pkg::*;

	logic [15:0] legal_cause;

	// Reserved codes can never be selected
	assign legal_cause = cause & `SDE_RSN_LEGAL;
	assign hit = |legal_cause;

	// Lowest code wins when the engine flags several causes at once
	always_comb begin
		reason = sde_reason_t'(`SDE_REASON_RST);
		for (int i = 15; i >= 0; i--) begin
			if (legal_cause[i]) begin
				reason = sde_reason_t'(4'(i));
			end
		end
	end

endmodule : sde_reason_encode

/* File: tb.sv */
// Self-checking bench for the drop-event status block.
// Assumes one clock; a bench mirror of status and mask gives expectations.
`timescale 1ns/1ps
`include "sde_drop_status_regs.svh"

module tb;
	import sde_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, drop_strobe = 1'b0;
	logic [15:0] reg_addr = 16'h0000, drop_cause = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, exp = 32'h0000_0000;
	logic [1:0] drop_src_port = 2'h0;
	logic switch_irq, msk = 1'b1, irq_exp = 1'b0;
	logic [14:0] st = 15'h0000;
	logic [4:0] e;
	int n_mismatch = 0, n_tests = 0, seed = 32'h4783, r;
	always #2 clock = ~clock;
	sde_drop_status uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.drop_strobe(drop_strobe), .drop_cause(drop_cause), .drop_src_port(drop_src_port),
		.switch_irq(switch_irq));
	// Lowest legal cause wins; top bit flags a hit
	function automatic logic [4:0] enc(input logic [15:0] c);
		logic [15:0] l;
		l = c & `SDE_RSN_LEGAL;
		for (int i = 0; i < 16; i++) if (l[i]) return {1'b1, 4'(i)};
		return 5'h00;
	endfunction : enc
	task chk(input string n, input logic [31:0] ex, got);
		n_tests++;
		if (got !== ex) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, ex, got);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// One cycle; a drop beside a status read lands after the clear
	// Outputs are compared one edge later, before that edge updates them
	task cyc(input logic wr, rd, input logic [15:0] a, input logic [31:0] wd,
		input logic dr, input logic [15:0] c, input logic [1:0] p);
		reg_wr <= wr;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= wd;
		drop_strobe <= dr;
		drop_cause <= c;
		drop_src_port <= p;
		@(posedge clock);
		// Still the answer to the previous access in this time step
		chk("reg_rdata", exp, reg_rdata);
		chk("switch_irq", {31'h0000_0000, irq_exp}, {31'h0000_0000, switch_irq});
		exp = 32'h0000_0000;
		if (rd && a == `SDE_ADDR_STATUS) begin
			exp = {17'h0_0000, st};
			st = 15'h0000;
		end
		if (rd && a == `SDE_ADDR_MASK) exp = {31'h0000_0000, msk};
		if (wr && a == `SDE_ADDR_MASK) msk = wd[0];
		e = enc(c);
		if (dr && e[4] && !st[1]) st[7:1] = {e[3:0], p, 1'b1};
		else if (dr && e[4] && !st[8]) st[14:8] = {e[3:0], p, 1'b1};
		if (dr) st[0] = 1'b1;
		irq_exp = st[0] & ~msk;
	endtask : cyc
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		cyc(0, 1, `SDE_ADDR_MASK, 0, 0, 0, 0);
		cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		for (int i = 0; i < 16; i++) begin
			cyc(0, 0, `SDE_ADDR_STATUS, 0, 1, 16'h0001 << i, i[1:0]);
			cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		end
		for (int i = 0; i < 3; i++) cyc(0, 0, 0, 0, 1, 16'h0400 >> i, 2'(i));
		cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		cyc(1, 0, `SDE_ADDR_MASK, 0, 0, 0, 0);
		cyc(0, 0, 0, 0, 1, 16'h4000, 2'h2);
		cyc(1, 0, `SDE_ADDR_MASK, 1, 0, 0, 0);
		cyc(1, 0, `SDE_ADDR_STATUS, 32'hFFFF_FFFF, 0, 0, 0);
		cyc(0, 1, 16'h6208, 0, 0, 0, 0);
		cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		repeat (400) begin
			r = $random(seed);
			cyc(r[0], r[1] & ~r[0], (r[9] & r[8]) ? 16'h6208 : r[8] ? `SDE_ADDR_MASK :
				`SDE_ADDR_STATUS, $random(seed), r[2], r[10] ? 16'h0001 << r[14:11] :
				r[31:16], r[4:3]);
		end
		// Mid-run reset: mask back to one, records gone
		cyc(0, 0, 0, 0, 0, 0, 0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		st = 15'h0000;
		msk = 1'b1;
		exp = 32'h0000_0000;
		irq_exp = 1'b0;
		cyc(0, 1, `SDE_ADDR_MASK, 0, 1, 16'h0002, 2'h1);
		cyc(0, 1, `SDE_ADDR_STATUS, 0, 0, 0, 0);
		cyc(0, 0, 0, 0, 0, 0, 0);
		print_verdict;
	end
endmodule : tb

bind sde_drop_status sde_drop_checker chk_i (.clock(clock), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .drop_strobe(drop_strobe), .switch_irq(switch_irq));
